// File: design/sdm_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdm_defs.svh"

module sdm_device (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // pins from the controller
   sdm_link_if.device link,
   // status
   output logic [3:0] rank_power_state,
   output logic burst_active
);

   // =====================================================================
   // state
   typedef struct packed {
      logic [1:0][`SDM_MODE_W-1:0] mode;
      logic [1:0][3:0] open_banks;
      sdm_pkg::sdm_pstate_t [1:0] pstate;
      logic busy;
      logic wr;
      logic rank;
      logic [1:0] bank;
      logic [`SDM_COL_W-1:0] col;
      logic [`SDM_COL_W-1:0] cnt;
      logic [4:0] left;
      logic auto_pre;
      logic [1:0] rd_vld;
      logic [1:0][`SDM_DATA_W-1:0] rd_pipe;
      logic [`SDM_LANES-1:0] mask_d1;
      logic [`SDM_DATA_W-1:0] dq_out;
      logic [`SDM_LANES-1:0] dq_oe;
   } sdm_dev_state_t;

   sdm_dev_state_t s_reg;
   sdm_dev_state_t s_next;

   // storage folded to rank, bank and low column bits
   logic [`SDM_DATA_W-1:0] mem [0:127];

   // =====================================================================
   // helpers
   function automatic sdm_pkg::sdm_cmd_t sdm_decode(input logic sel_n,
         input logic [2:0] strobes);
      if (sel_n) begin
         sdm_decode = sdm_pkg::CMD_INHIBIT;
      end else begin
         sdm_decode = sdm_pkg::sdm_cmd_t'({1'b0, strobes});
      end
   endfunction

   function automatic logic [3:0] sdm_burst_col(input logic [3:0] start,
         input logic [3:0] cnt, input logic [9:0] mode);
      logic [3:0] m;
      m = 4'(sdm_pkg::sdm_burst_len(mode[`SDM_BL_LSB+:3]) - 5'h01);
      if (mode[`SDM_ORDER_BIT]) begin
         sdm_burst_col = start ^ (cnt & m);
      end else begin
         sdm_burst_col = (start & ~m) | ((start + cnt) & m);
      end
   endfunction

   // =====================================================================
   // decoded pins, sampled only at the rising edge
   logic [2:0] strobes;
   logic [1:0] gate;
   logic [1:0] live;
   logic [1:0] bank_in;
   sdm_pkg::sdm_cmd_t cmd [0:1];
   logic [9:0] op_code;

   assign strobes = {link.row_strobe_n, link.col_strobe_n,
                     link.write_strobe_n};
   assign gate = {link.clock_gate_rank1, link.clock_gate_rank0};
   assign bank_in = {link.bank_select_1, link.bank_select_0};
   assign cmd[0] = sdm_decode(link.rank0_select_n, strobes);
   assign cmd[1] = sdm_decode(link.rank1_select_n, strobes);
   assign op_code = link.addr[`SDM_MODE_W-1:0];

   // a rank acts only when running and its gate is high
   always_comb begin
      for (int r = 0; r < 2; r++) begin
         live[r] = (s_reg.pstate[r] == sdm_pkg::PS_RUN) && gate[r];
      end
   end

   // =====================================================================
   // beat selection: new read or write, or burst continuation
   logic suspend;
   logic new_rw;
   logic new_rank;
   logic stop;
   logic beat_go;
   logic beat_wr;
   logic beat_rank;
   logic [1:0] beat_bank;
   logic [3:0] beat_col;
   logic [6:0] beat_addr;
   logic [`SDM_DATA_W-1:0] rd_word;

   always_comb begin
      new_rw = 1'b0;
      new_rank = 1'b0;
      stop = 1'b0;
      for (int r = 1; r >= 0; r--) begin
         if (live[r] && (cmd[r] == sdm_pkg::CMD_READ ||
               cmd[r] == sdm_pkg::CMD_WRITE)) begin
            new_rw = 1'b1;
            new_rank = 1'(r);
         end
         if (live[r] && cmd[r] == sdm_pkg::CMD_TERMINATE &&
               s_reg.rank == 1'(r)) begin
            stop = 1'b1;
         end
      end
      suspend = s_reg.busy && !gate[s_reg.rank];
      beat_go = 1'b0;
      beat_wr = s_reg.wr;
      beat_rank = s_reg.rank;
      beat_bank = s_reg.bank;
      beat_col = sdm_burst_col(s_reg.col, s_reg.cnt,
                               s_reg.mode[s_reg.rank]);
      if (new_rw) begin
         beat_go = 1'b1;
         beat_wr = (cmd[new_rank] == sdm_pkg::CMD_WRITE);
         beat_rank = new_rank;
         beat_bank = bank_in;
         beat_col = link.addr[`SDM_COL_LSB+:`SDM_COL_W];
      end else if (s_reg.busy && !suspend && !stop) begin
         beat_go = 1'b1;
      end
      beat_addr = {beat_rank, beat_bank, beat_col};
   end

   assign rd_word = mem[beat_addr];

   // masked lanes keep their old contents; one process owns the array
   always_ff @(posedge clock) begin
      for (int l = 0; l < `SDM_LANES; l++) begin
         if (beat_go && beat_wr && !link.byte_lane_mask_bus[l]) begin
            mem[beat_addr][l*8+:8] <= link.data_lines[l*8+:8];
         end
      end
   end

   // =====================================================================
   // next state
   logic [4:0] len;
   logic cl3;

   always_comb begin
      s_next = s_reg;
      len = sdm_pkg::sdm_burst_len(
         s_reg.mode[new_rank][`SDM_BL_LSB+:3]);
      if (cmd[new_rank] == sdm_pkg::CMD_WRITE &&
            s_reg.mode[new_rank][`SDM_WBM_BIT]) begin
         len = 5'h01; // single-location writes
      end
      cl3 = (s_reg.mode[s_reg.rank][`SDM_CL_LSB+:3] == `SDM_CL3_CODE);
      // read pipeline and output registers, frozen while suspended; the mask delay always advances
      s_next.mask_d1 = link.byte_lane_mask_bus;
      if (!suspend) begin
         s_next.rd_pipe[1] = s_reg.rd_pipe[0];
         s_next.rd_vld[1] = s_reg.rd_vld[0];
         s_next.rd_pipe[0] = rd_word;
         s_next.rd_vld[0] = beat_go && !beat_wr;
         s_next.dq_out = cl3 ? s_reg.rd_pipe[1] : s_reg.rd_pipe[0];
         if (cl3 ? s_reg.rd_vld[1] : s_reg.rd_vld[0]) begin
            s_next.dq_oe = ~s_reg.mask_d1;
         end else begin
            s_next.dq_oe = 8'h00;
         end
      end
      // burst counter
      if (new_rw) begin
         s_next.busy = (len > 5'h01);
         s_next.wr = beat_wr;
         s_next.rank = new_rank;
         s_next.bank = bank_in;
         s_next.col = beat_col;
         s_next.cnt = 4'h1;
         s_next.left = len - 5'h01;
         s_next.auto_pre = link.addr[`SDM_SCOPE_BIT];
         if (len == 5'h01 && link.addr[`SDM_SCOPE_BIT]) begin
            s_next.open_banks[new_rank][bank_in] = 1'b0;
         end
      end else if (beat_go) begin
         s_next.cnt = s_reg.cnt + 4'h1;
         s_next.left = s_reg.left - 5'h01;
         if (s_reg.left == 5'h01) begin
            s_next.busy = 1'b0;
            if (s_reg.auto_pre) begin
               s_next.open_banks[s_reg.rank][s_reg.bank] = 1'b0;
            end
         end
      end else if (stop) begin
         s_next.busy = 1'b0;
      end
      // per-rank commands and power states
      for (int r = 0; r < 2; r++) begin
         case (s_reg.pstate[r])
            sdm_pkg::PS_RUN: begin
               if (!gate[r]) begin
                  if (cmd[r] == sdm_pkg::CMD_REFRESH) begin
                     s_next.pstate[r] = sdm_pkg::PS_SELF;
                  end else if (s_reg.busy && s_reg.rank == 1'(r)) begin
                     s_next.pstate[r] = sdm_pkg::PS_RUN;
                  end else if (s_reg.open_banks[r] != 4'h0) begin
                     s_next.pstate[r] = sdm_pkg::PS_PDN_ACT;
                  end else begin
                     s_next.pstate[r] = sdm_pkg::PS_PDN_PRE;
                  end
               end else begin
                  case (cmd[r])
                     sdm_pkg::CMD_ACTIVATE: begin
                        s_next.open_banks[r][bank_in] = 1'b1;
                     end
                     sdm_pkg::CMD_PRECHARGE: begin
                        if (link.addr[`SDM_SCOPE_BIT]) begin
                           s_next.open_banks[r] = 4'h0;
                        end else begin
                           s_next.open_banks[r][bank_in] = 1'b0;
                        end
                     end
                     sdm_pkg::CMD_LOAD_MODE: begin
                        if (s_reg.open_banks[r] == 4'h0) begin
                           s_next.mode[r] = op_code;
                        end
                     end
                     default: begin
                     end
                  endcase
               end
            end
            default: begin
               // receivers off: only the gate level is looked at
               if (gate[r]) begin
                  s_next.pstate[r] = sdm_pkg::PS_RUN;
               end
            end
         endcase
      end
   end

   // =====================================================================
   // state register
   always_ff @(posedge clock) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.mode <= {`SDM_MODE_RST, `SDM_MODE_RST};
      end else begin
         s_reg <= s_next;
      end
   end

   // =====================================================================
   // outputs
   assign link.dev_data_out = s_reg.dq_out;
   assign link.dev_data_oe = s_reg.dq_oe;
   assign rank_power_state = {s_reg.pstate[1], s_reg.pstate[0]};
   assign burst_active = s_reg.busy;

endmodule

`default_nettype wire

// File: design/sdm_defs.svh
`ifndef SDM_DEFS_SVH
`define SDM_DEFS_SVH

// =====================================================================
// clock and timing
`define SDM_CLK_NS 8
`define SDM_INIT_NS 100000
`define SDM_INIT_CYCLES ((`SDM_INIT_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS)

// =====================================================================
// bus widths
`define SDM_LANES 8
`define SDM_DATA_W 64
`define SDM_ADDR_W 13

// =====================================================================
// address and op-code field positions
`define SDM_SCOPE_BIT 10
`define SDM_COL_LSB 0
`define SDM_COL_W 4
`define SDM_BL_LSB 0
`define SDM_ORDER_BIT 3
`define SDM_CL_LSB 4
`define SDM_OPMODE_LSB 7
`define SDM_WBM_BIT 9
`define SDM_MODE_W 10

// =====================================================================
// reset values and field codes
`define SDM_MODE_RST 10'h020
`define SDM_CL3_CODE 3'h3
`define SDM_FULL_PAGE_CODE 3'h7
`define SDM_PAGE_BEATS 5'h10

`endif

// File: design/sdm_pkg.sv
package sdm_pkg;

   // command code: {select_n, row_n, col_n, write_n}
   typedef enum logic [3:0] {
      CMD_LOAD_MODE = 4'h0,
      CMD_REFRESH = 4'h1,
      CMD_PRECHARGE = 4'h2,
      CMD_ACTIVATE = 4'h3,
      CMD_WRITE = 4'h4,
      CMD_READ = 4'h5,
      CMD_TERMINATE = 4'h6,
      CMD_NOP = 4'h7,
      CMD_INHIBIT = 4'h8
   } sdm_cmd_t;

   // per-rank power state
   typedef enum logic [1:0] {
      PS_RUN = 2'b00,
      PS_PDN_PRE = 2'b01,
      PS_PDN_ACT = 2'b10,
      PS_SELF = 2'b11
   } sdm_pstate_t;

   // burst length in beats from the length field
   function automatic logic [4:0] sdm_burst_len(input logic [2:0] code);
      case (code)
         3'h0: sdm_burst_len = 5'h01;
         3'h1: sdm_burst_len = 5'h02;
         3'h2: sdm_burst_len = 5'h04;
         3'h3: sdm_burst_len = 5'h08;
         3'h7: sdm_burst_len = 5'h10;
         default: sdm_burst_len = 5'h01;
      endcase
   endfunction

endpackage

// File: design/sdm_link_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdm_defs.svh"

// =====================================================================
// command and data pins between controller and module
interface sdm_link_if;
   logic rank0_select_n;
   logic rank1_select_n;
   logic clock_gate_rank0;
   logic clock_gate_rank1;
   logic row_strobe_n;
   logic col_strobe_n;
   logic write_strobe_n;
   logic bank_select_0;
   logic bank_select_1;
   logic [`SDM_ADDR_W-1:0] addr;
   logic [`SDM_LANES-1:0] byte_lane_mask_bus;
   logic [`SDM_DATA_W-1:0] host_data_out;
   logic [`SDM_LANES-1:0] host_data_oe;
   logic [`SDM_DATA_W-1:0] dev_data_out;
   logic [`SDM_LANES-1:0] dev_data_oe;
   logic [`SDM_DATA_W-1:0] data_lines;

   // resolved data level per lane, device drive first
   genvar l;
   for (l = 0; l < `SDM_LANES; l++) begin : g_lane
      assign data_lines[l*8+:8] = dev_data_oe[l] ? dev_data_out[l*8+:8] :
         (host_data_oe[l] ? host_data_out[l*8+:8] : 8'h00);
   end

   modport host (
      output rank0_select_n, rank1_select_n, clock_gate_rank0,
      output clock_gate_rank1, row_strobe_n, col_strobe_n,
      output write_strobe_n, bank_select_0, bank_select_1, addr,
      output byte_lane_mask_bus, host_data_out, host_data_oe,
      input data_lines
   );

   modport device (
      input rank0_select_n, rank1_select_n, clock_gate_rank0,
      input clock_gate_rank1, row_strobe_n, col_strobe_n,
      input write_strobe_n, bank_select_0, bank_select_1, addr,
      input byte_lane_mask_bus, data_lines,
      output dev_data_out, dev_data_oe
   );
endinterface

`default_nettype wire

// File: design/sdm_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdm_defs.svh"

module sdm_host #(
   parameter int INIT_CYCLES = `SDM_INIT_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // user command port
   input wire logic cmd_valid,
   input wire sdm_pkg::sdm_cmd_t cmd_code,
   input wire logic cmd_rank,
   input wire logic [1:0] cmd_bank,
   input wire logic [`SDM_ADDR_W-1:0] cmd_addr,
   input wire logic [`SDM_DATA_W-1:0] cmd_data,
   input wire logic cmd_data_en,
   input wire logic [`SDM_LANES-1:0] cmd_mask,
   output logic cmd_ready,
   // power requests, one per rank
   input wire logic [1:0] sleep_req,
   // read results and status
   output logic [`SDM_DATA_W-1:0] rd_data,
   output logic rd_valid,
   output logic init_done,
   // pins to the module
   sdm_link_if.host link
);

   // =====================================================================
   // state
   typedef struct packed {
      logic [15:0] init_cnt;
      logic ready;
      logic [1:0] sel_n;
      logic [2:0] strobes;
      logic [1:0] bank;
      logic [`SDM_ADDR_W-1:0] addr;
      logic [`SDM_LANES-1:0] mask;
      logic [`SDM_DATA_W-1:0] dq_out;
      logic [`SDM_LANES-1:0] dq_oe;
      logic [1:0] gate;
      logic cl3;
      logic [2:0] bl_code;
      logic [2:0] cap_wait;
      logic [4:0] cap_left;
      logic [`SDM_DATA_W-1:0] rd_data;
      logic rd_valid;
   } sdm_host_state_t;

   sdm_host_state_t s_reg;
   sdm_host_state_t s_next;
   logic take;
   logic cap;

   // =====================================================================
   // next state
   always_comb begin
      s_next = s_reg;
      take = s_reg.ready && cmd_valid;
      cap = (s_reg.cap_wait == 3'h1) ||
            (s_reg.cap_wait == 3'h0 && s_reg.cap_left != 5'h00);
      // power-up wait with the pins held at inhibit
      if (!s_reg.ready) begin
         if (s_reg.init_cnt == 16'(INIT_CYCLES - 1)) begin
            s_next.ready = 1'b1;
         end else begin
            s_next.init_cnt = s_reg.init_cnt + 16'h0001;
         end
      end else begin
         s_next.gate = ~sleep_req;
      end
      // drive one command per accepted cycle, inhibit otherwise
      s_next.sel_n = 2'b11;
      s_next.strobes = 3'h7;
      s_next.mask = 8'h00;
      s_next.dq_oe = 8'h00;
      if (take && cmd_code != sdm_pkg::CMD_INHIBIT) begin
         s_next.sel_n = cmd_rank ? 2'b01 : 2'b10;
         s_next.strobes = cmd_code[2:0];
         s_next.bank = cmd_bank;
         s_next.addr = cmd_addr;
         s_next.mask = cmd_mask;
         s_next.dq_out = cmd_data;
         s_next.dq_oe = cmd_data_en ? 8'hff : 8'h00;
         if (cmd_code == sdm_pkg::CMD_LOAD_MODE) begin
            s_next.cl3 = (cmd_addr[`SDM_CL_LSB+:3] == `SDM_CL3_CODE);
            s_next.bl_code = cmd_addr[`SDM_BL_LSB+:3];
         end
      end
      // read capture: latency plus one edge, then burst beats
      s_next.rd_valid = 1'b0;
      if (s_reg.cap_wait != 3'h0) begin
         s_next.cap_wait = s_reg.cap_wait - 3'h1;
      end
      if (cap) begin
         s_next.rd_valid = 1'b1;
         s_next.rd_data = link.data_lines;
         s_next.cap_left = s_reg.cap_left - 5'h01;
      end
      if (take && cmd_code == sdm_pkg::CMD_READ) begin
         s_next.cap_wait = s_reg.cl3 ? 3'h4 : 3'h3;
         s_next.cap_left = sdm_pkg::sdm_burst_len(s_reg.bl_code);
      end
   end

   // =====================================================================
   // state register
   always_ff @(posedge clock) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.sel_n <= 2'b11;
         s_reg.strobes <= 3'h7;
         s_reg.gate <= 2'b11;
      end else begin
         s_reg <= s_next;
      end
   end

   // =====================================================================
   // outputs
   assign link.rank0_select_n = s_reg.sel_n[0];
   assign link.rank1_select_n = s_reg.sel_n[1];
   assign link.clock_gate_rank0 = s_reg.gate[0];
   assign link.clock_gate_rank1 = s_reg.gate[1];
   assign link.row_strobe_n = s_reg.strobes[2];
   assign link.col_strobe_n = s_reg.strobes[1];
   assign link.write_strobe_n = s_reg.strobes[0];
   assign link.bank_select_0 = s_reg.bank[0];
   assign link.bank_select_1 = s_reg.bank[1];
   assign link.addr = s_reg.addr;
   assign link.byte_lane_mask_bus = s_reg.mask;
   assign link.host_data_out = s_reg.dq_out;
   assign link.host_data_oe = s_reg.dq_oe;
   assign cmd_ready = s_reg.ready;
   assign init_done = s_reg.ready;
   assign rd_data = s_reg.rd_data;
   assign rd_valid = s_reg.rd_valid;

endmodule

`default_nettype wire

// File: verification/sdm_link_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdm_defs.svh"

// =====================================================================
// link checker
module sdm_link_sva #(
   parameter int INIT_CYCLES = 20
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // link pins
   input wire logic rank0_select_n,
   input wire logic rank1_select_n,
   input wire logic clock_gate_rank0,
   input wire logic clock_gate_rank1,
   input wire logic [`SDM_LANES-1:0] byte_lane_mask_bus,
   input wire logic [`SDM_LANES-1:0] host_data_oe,
   input wire logic [`SDM_LANES-1:0] dev_data_oe
);
   int icnt;
   int qcnt;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   // edges since reset, and since any selected or gated cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         icnt <= 0;
         qcnt <= 0;
      end else begin
         icnt <= (icnt < INIT_CYCLES) ? icnt + 1 : icnt;
         if (!(rank0_select_n && rank1_select_n && clock_gate_rank0 &&
               clock_gate_rank1))
            qcnt <= 0;
         else if (qcnt < 100)
            qcnt <= qcnt + 1;
      end
   end

   reset_quiet_a: assert property (
      $fell(reset) |-> rank0_select_n && rank1_select_n && !host_data_oe)
      else $error("pins not idle after reset");
   init_inhibit_a: assert property (
      icnt < INIT_CYCLES |-> rank0_select_n && rank1_select_n)
      else $error("command during power-up wait");
   init_gate_a: assert property (
      icnt < INIT_CYCLES |-> clock_gate_rank0 && clock_gate_rank1)
      else $error("clock gate low during power-up wait");
   one_rank_a: assert property (
      !(!rank0_select_n && !rank1_select_n))
      else $error("both ranks selected");
   mask_off_a: assert property (
      |byte_lane_mask_bus |-> ##2 !(dev_data_oe & $past(byte_lane_mask_bus, 2)))
      else $error("masked lane driven two edges later");
   mask_lanes_a: assert property (
      dev_data_oe != 8'h00 && clock_gate_rank0 && clock_gate_rank1 &&
      $past(clock_gate_rank0) && $past(clock_gate_rank1)
      |-> dev_data_oe == ~$past(byte_lane_mask_bus, 2))
      else $error("driven lanes differ from mask");
   quiet_drive_a: assert property (
      dev_data_oe != 8'h00 |-> qcnt < 20)
      else $error("module drives without a command");
   no_clash_a: assert property (
      (host_data_oe & dev_data_oe) == 8'h00)
      else $error("both ends drive one lane");
endmodule

`default_nettype wire

// File: verification/sdram_module_command_pins_bench.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// both ends joined, driven from the host user port
module sdram_module_command_pins_bench;
   localparam int INIT = 20;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid = 1'b0;
   sdm_pkg::sdm_cmd_t cmd_code = sdm_pkg::CMD_NOP;
   logic cmd_rank = 1'b0;
   logic [1:0] cmd_bank = 2'h0;
   logic [12:0] cmd_addr = 13'h0000;
   logic [63:0] cmd_data = 64'h0;
   logic cmd_data_en = 1'b0;
   logic [7:0] cmd_mask = 8'h00;
   logic [1:0] sleep_req = 2'h0;
   logic cmd_ready, rd_valid, init_done, burst_active;
   logic [63:0] rd_data;
   logic [3:0] rank_power_state;
   int n_fail = 0;
   int tests_run = 0;
   int cyc = 0;
   logic [63:0] expq[$];

   sdm_link_if link();
   sdm_host #(.INIT_CYCLES(INIT)) sdm_host_i (.clock(clock), .reset(reset),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_rank(cmd_rank),
      .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .cmd_data_en(cmd_data_en), .cmd_mask(cmd_mask), .cmd_ready(cmd_ready),
      .sleep_req(sleep_req), .rd_data(rd_data), .rd_valid(rd_valid),
      .init_done(init_done), .link(link));
   sdm_device sdm_device_i (.clock(clock), .reset(reset), .link(link),
      .rank_power_state(rank_power_state), .burst_active(burst_active));
   sdm_link_sva #(.INIT_CYCLES(INIT)) sdm_link_sva_i (.clock(clock),
      .reset(reset), .rank0_select_n(link.rank0_select_n),
      .rank1_select_n(link.rank1_select_n),
      .clock_gate_rank0(link.clock_gate_rank0),
      .clock_gate_rank1(link.clock_gate_rank1),
      .byte_lane_mask_bus(link.byte_lane_mask_bus),
      .host_data_oe(link.host_data_oe), .dev_data_oe(link.dev_data_oe));

   // clock and hang guard
   always #4 clock = ~clock;
   always @(posedge clock) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         complete_run();
      end
   end

   // =====================================================================
   // shared tasks
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         n_fail++;
      end
   endtask

   function automatic logic [63:0] wd(input int i);
      return 64'h0123456789abcdef + 64'(i) * 64'h1111111111111111;
   endfunction

   function automatic logic [63:0] lanes(input logic [7:0] m);
      for (int l = 0; l < 8; l++)
         lanes[l*8+:8] = {8{m[l]}};
   endfunction

   // one command taken at the next edge; data driven with write and nop commands
   task automatic cmd(input sdm_pkg::sdm_cmd_t c, input logic r,
      input logic [1:0] b, input logic [12:0] a, input logic [63:0] d,
      input logic [7:0] m);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_rank <= r;
      cmd_bank <= b;
      cmd_addr <= a;
      cmd_data <= d;
      cmd_data_en <= (c == sdm_pkg::CMD_WRITE || c == sdm_pkg::CMD_NOP);
      cmd_mask <= m;
      @(posedge clock);
   endtask

   task automatic idle(input int n);
      cmd_valid <= 1'b0;
      cmd_data_en <= 1'b0;
      cmd_mask <= 8'h00;
      repeat (n) @(posedge clock);
   endtask

   // compares read beats with the queue; a surplus beat always mismatches
   task automatic collect();
      repeat (12) begin
         @(negedge clock);
         if (rd_valid === 1'b1)
            check(rd_data, expq.size() > 0 ? expq.pop_front() : ~rd_data);
      end
      check(64'(expq.size()), 64'h0);
      @(posedge clock);
   endtask

   // counts cycles in which the module drives any lane
   task automatic beats(input int n);
      int k;
      k = 0;
      repeat (12) begin
         @(negedge clock);
         if (link.dev_data_oe != 8'h00)
            k++;
      end
      check(64'(k), 64'(n));
      @(posedge clock);
   endtask

   // =====================================================================
   // scenarios
   task automatic t_init();
      @(negedge clock);
      check({63'h0, cmd_ready}, 64'h0);
      repeat (INIT + 4) @(posedge clock);
      check({63'h0, init_done}, 64'h1);
      @(posedge clock);
   endtask

   // sequential then interleaved bursts of four, with wrap
   task automatic t_burst();
      cmd(sdm_pkg::CMD_LOAD_MODE, 1'b0, 2'h0, 13'h0022, '0, 8'h00);
      cmd(sdm_pkg::CMD_ACTIVATE, 1'b0, 2'h1, 13'h1abc, '0, 8'h00);
      cmd(sdm_pkg::CMD_WRITE, 1'b0, 2'h1, 13'h000d, wd(0), 8'h00);
      for (int i = 1; i < 4; i++)
         cmd(sdm_pkg::CMD_NOP, 1'b0, 2'h1, 13'h0, wd(i), 8'h00);
      idle(0);
      @(negedge clock);
      check({63'h0, burst_active}, 64'h1);
      repeat (2) @(posedge clock);
      check({63'h0, burst_active}, 64'h0);
      expq = '{wd(3), wd(0), wd(1), wd(2)};
      cmd(sdm_pkg::CMD_READ, 1'b0, 2'h1, 13'h000c, '0, 8'h00);
      idle(0);
      collect();
      cmd(sdm_pkg::CMD_PRECHARGE, 1'b0, 2'h0, 13'h0400, '0, 8'h00);
      cmd(sdm_pkg::CMD_LOAD_MODE, 1'b0, 2'h0, 13'h002a, '0, 8'h00);
      cmd(sdm_pkg::CMD_ACTIVATE, 1'b0, 2'h1, 13'h0000, '0, 8'h00);
      cmd(sdm_pkg::CMD_ACTIVATE, 1'b0, 2'h2, 13'h0000, '0, 8'h00);
      for (int i = 0; i < 4; i++)
         cmd(i ? sdm_pkg::CMD_NOP : sdm_pkg::CMD_WRITE, 1'b0, 2'h2, 13'h000d,
            ~wd(i), 8'h00);
      idle(2);
      expq = '{wd(0), wd(3), wd(2), wd(1)};
      cmd(sdm_pkg::CMD_READ, 1'b0, 2'h1, 13'h000d, '0, 8'h00);
      idle(0);
      collect();
      expq = '{~wd(0), ~wd(1), ~wd(2), ~wd(3)};
      cmd(sdm_pkg::CMD_READ, 1'b0, 2'h2, 13'h000d, '0, 8'h00);
      idle(0);
      collect();
   endtask

   // per-beat write masks over old data, then a masked first read beat
   task automatic t_mask();
      logic [7:0] mk[4];
      mk = '{8'h81, 8'h02, 8'h00, 8'hff};
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 4; i++)
            cmd(i ? sdm_pkg::CMD_NOP : sdm_pkg::CMD_WRITE, 1'b0, 2'h1,
               13'h0004, p ? ~wd(4 + i) : wd(4 + i), p ? mk[i] : 8'h00);
         idle(1);
      end
      for (int i = 0; i < 4; i++)
         expq.push_back(((wd(4 + i) & lanes(mk[i])) |
            (~wd(4 + i) & ~lanes(mk[i]))) & (i ? '1 : ~lanes(8'h10)));
      cmd(sdm_pkg::CMD_READ, 1'b0, 2'h1, 13'h0004, '0, 8'h10);
      idle(0);
      collect();
   endtask

   // deselect, then mode load refused until all banks are precharged
   task automatic t_scope();
      cmd(sdm_pkg::CMD_INHIBIT, 1'b0, 2'h1, 13'h0000, '0, 8'h00);
      idle(0);
      beats(0);
      cmd(sdm_pkg::CMD_READ, 1'b1, 2'h1, 13'h0000, '0, 8'h00);
      idle(0);
      beats(1);
      for (int p = 0; p < 2; p++) begin
         cmd(sdm_pkg::CMD_PRECHARGE, 1'b0, 2'h2, p ? 13'h0400 : 13'h0, '0,
            8'h00);
         cmd(sdm_pkg::CMD_LOAD_MODE, 1'b0, 2'h0, 13'h0030, '0, 8'h00);
         cmd(p ? sdm_pkg::CMD_ACTIVATE : sdm_pkg::CMD_NOP, 1'b0, 2'h1,
            13'h0000, '0, 8'h00);
         cmd(sdm_pkg::CMD_READ, 1'b0, 2'h1, 13'h0000, '0, 8'h00);
         idle(0);
         beats(p ? 1 : 4);
      end
   endtask

   // power states by clock gate, reads ignored while down
   task automatic t_power();
      sdm_pkg::sdm_pstate_t ps[3];
      ps = '{sdm_pkg::PS_PDN_ACT, sdm_pkg::PS_PDN_PRE, sdm_pkg::PS_SELF};
      for (int p = 0; p < 3; p++) begin
         if (p == 2)
            sleep_req <= 2'b01;
         cmd(p == 2 ? sdm_pkg::CMD_REFRESH : sdm_pkg::CMD_PRECHARGE, 1'b0,
            2'h3, p == 1 ? 13'h0400 : 13'h0000, '0, 8'h00);
         sleep_req <= 2'b01;
         cmd(sdm_pkg::CMD_READ, 1'b0, 2'h1, 13'h0000, '0, 8'h00);
         idle(0);
         beats(0);
         check(64'(rank_power_state), 64'(ps[p]));
         sleep_req <= 2'b00;
         idle(4);
         check(64'(rank_power_state), 64'h0);
      end
   endtask

   // =====================================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_init();
      t_burst();
      t_mask();
      t_scope();
      t_power();
      complete_run();
   end
endmodule

`default_nettype wire
